// ==== gap_timer.v ====
// Loadable down counter used as the start and gap delay timer
`timescale 1ns/1ps

module gap_timer (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Control
  input wire load_i,
  input wire clear_i,
  input wire [31:0] count_i,
  // Status
  output reg done_o
);

  reg [31:0] remain;
  reg running;

  // Count down after a load; done pulses when it reaches one
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remain <= 32'h0;
      running <= 1'b0;
      done_o <= 1'b0;
    end else if (clear_i) begin
      remain <= 32'h0;
      running <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      remain <= (count_i == 32'h0) ? 32'h1 : count_i;
      running <= 1'b1;
      done_o <= 1'b0;
    end else if (running) begin
      if (remain <= 32'h1) begin
        running <= 1'b0;
        done_o <= 1'b1;
      end else begin
        remain <= remain - 32'h1;
        done_o <= 1'b0;
      end
    end else begin
      done_o <= 1'b0;
    end
  end

endmodule

// ==== quad_rail_enable_sequencer.v ====
// Quad rail enable sequencer: window check, start delay, ordered enables
`timescale 1ns/1ps
`include "seq_regs.vh"

module quad_rail_enable_sequencer (
  // Clock and reset (bias power-on reset)
  input wire clk_i,
  input wire rst_n_i,
  // Comparator levels from the monitored rail
  input wire low_limit_sense_i,
  input wire high_limit_sense_i,
  // Sequence request pin, already resolved with its pull-up
  input wire sequence_request_i,
  // Programmed timing codes
  input wire [15:0] start_delay_capacitor_i,
  input wire [15:0] gap_resistor_ab_i,
  input wire [15:0] gap_resistor_bc_i,
  input wire [15:0] gap_resistor_cd_i,
  // Open-drain enables: pin level is high while the enable is low
  output reg [3:0] rail_enable_o,
  output reg [3:0] rail_enable_oe_o,
  // Open-drain fault
  output reg fault_o,
  output reg fault_oe_o
);

  // ****************************************
  // States
  // ****************************************
  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_ON_GAP = 3'h2;
  localparam ST_ON = 3'h3;
  localparam ST_OFF_DLY = 3'h4;
  localparam ST_OFF_GAP = 3'h5;

  // ****************************************
  // Input synchronizers
  // ****************************************
  reg [2:0] sync_a;
  reg [2:0] sync_b;
  wire uv_ok;
  wire ov_high;
  wire req;

  // Two flops on each asynchronous level
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {sequence_request_i, high_limit_sense_i, low_limit_sense_i};
      sync_b <= sync_a;
    end
  end

  assign uv_ok = sync_b[0];
  assign ov_high = sync_b[1];
  assign req = sync_b[2];

  // Rail inside its window
  wire in_window;
  assign in_window = uv_ok & ~ov_high;

  // ****************************************
  // Timing code synchronizers
  // ****************************************
  reg [15:0] start_code_a;
  reg [15:0] start_code;
  reg [15:0] ab_code_a;
  reg [15:0] ab_code;
  reg [15:0] bc_code_a;
  reg [15:0] bc_code;
  reg [15:0] cd_code_a;
  reg [15:0] cd_code;

  // Codes are static straps; two flops keep a late strap change clean
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_code_a <= 16'h0;
      start_code <= 16'h0;
      ab_code_a <= 16'h0;
      ab_code <= 16'h0;
      bc_code_a <= 16'h0;
      bc_code <= 16'h0;
      cd_code_a <= 16'h0;
      cd_code <= 16'h0;
    end else begin
      start_code_a <= start_delay_capacitor_i;
      start_code <= start_code_a;
      ab_code_a <= gap_resistor_ab_i;
      ab_code <= ab_code_a;
      bc_code_a <= gap_resistor_bc_i;
      bc_code <= bc_code_a;
      cd_code_a <= gap_resistor_cd_i;
      cd_code <= cd_code_a;
    end
  end

  // ****************************************
  // Delay counts
  // ****************************************
  wire [31:0] start_cnt;
  wire [31:0] gap_ab_cnt;
  wire [31:0] gap_bc_cnt;
  wire [31:0] gap_cd_cnt;

  // Scale codes into cycle counts
  assign start_cnt = {16'h0, start_code} *
    `START_CYC_PER_UNIT;
  assign gap_ab_cnt = {16'h0, ab_code} * `GAP_CYC_PER_UNIT;
  assign gap_bc_cnt = {16'h0, bc_code} * `GAP_CYC_PER_UNIT;
  assign gap_cd_cnt = {16'h0, cd_code} * `GAP_CYC_PER_UNIT;

  // ****************************************
  // Sequencer state
  // ****************************************
  reg [2:0] state;
  reg [2:0] step;
  reg [3:0] en;
  reg tmr_load;
  reg tmr_clear;
  reg [31:0] tmr_count;
  wire tmr_done_raw;
  wire tmr_done;

  reg [2:0] next_state;
  reg [2:0] next_step;
  reg [3:0] next_en;
  reg next_load;
  reg next_clear;
  reg [31:0] next_count;

  gap_timer u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .load_i(tmr_load),
    .clear_i(tmr_clear),
    .count_i(tmr_count),
    .done_o(tmr_done_raw)
  );

  // A done pulse of the old count can land while a new count loads
  // (request dropped mid-gap); masked so it cannot step the sequence
  assign tmr_done = tmr_done_raw & ~tmr_load;

  // Gap count for the gap above a given enable count
  function [31:0] gap_for;
    input [2:0] n;
    begin
      case (n)
        3'h1: gap_for = gap_ab_cnt;
        3'h2: gap_for = gap_bc_cnt;
        default: gap_for = gap_cd_cnt;
      endcase
    end
  endfunction

  // Next state and timer control
  always @* begin
    next_state = state;
    next_step = step;
    next_en = en;
    next_load = 1'b0;
    next_clear = 1'b0;
    next_count = tmr_count;
    if (!in_window) begin
      // Any window fault drops everything at once
      next_state = ST_IDLE;
      next_step = `STEP_NONE;
      next_en = 4'h0;
      next_clear = 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          if (req) begin
            next_state = ST_START;
            next_load = 1'b1;
            next_count = start_cnt;
          end
        end
        ST_START: begin
          if (!req) begin
            next_state = ST_IDLE;
            next_clear = 1'b1;
          end else if (tmr_done) begin
            next_en = 4'h1;
            next_step = 3'h1;
            next_clear = 1'b0;
            next_load = 1'b1;
            next_count = gap_ab_cnt;
            next_state = ST_ON_GAP;
          end
        end
        ST_ON_GAP: begin
          if (!req) begin
            next_state = ST_OFF_DLY;
            next_load = 1'b1;
            next_count = start_cnt;
          end else if (tmr_done) begin
            next_en = {en[2:0], 1'b1};
            next_step = step + 3'h1;
            if (step == 3'h3) begin
              next_state = ST_ON;
            end else begin
              next_load = 1'b1;
              next_count = gap_for(step + 3'h1);
            end
          end
        end
        ST_ON: begin
          if (!req) begin
            next_state = ST_OFF_DLY;
            next_load = 1'b1;
            next_count = start_cnt;
          end
        end
        ST_OFF_DLY: begin
          if (tmr_done) begin
            // Drop the highest enable that is on
            next_en = {1'b0, en[3:1]} & en;
            next_step = step - 3'h1;
            if (step <= 3'h1) begin
              next_state = ST_IDLE;
            end else begin
              next_state = ST_OFF_GAP;
              next_load = 1'b1;
              next_count = gap_for(step - 3'h1);
            end
          end
        end
        ST_OFF_GAP: begin
          if (tmr_done) begin
            next_en = {1'b0, en[3:1]} & en;
            next_step = step - 3'h1;
            if (step <= 3'h1) begin
              next_state = ST_IDLE;
            end else begin
              next_load = 1'b1;
              next_count = gap_for(step - 3'h1);
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_en = 4'h0;
          next_step = `STEP_NONE;
          next_clear = 1'b1;
        end
      endcase
    end
  end

  // State registers
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      step <= `STEP_NONE;
      en <= 4'h0;
      tmr_load <= 1'b0;
      tmr_clear <= 1'b1;
      tmr_count <= 32'h0;
    end else begin
      state <= next_state;
      step <= next_step;
      en <= next_en;
      tmr_load <= next_load;
      tmr_clear <= next_clear;
      tmr_count <= next_count;
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  // Enables pull low while off; fault pulls low while compliant
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rail_enable_o <= 4'h0;
      rail_enable_oe_o <= 4'hf;
      fault_o <= 1'b0;
      fault_oe_o <= 1'b0;
    end else begin
      rail_enable_o <= 4'h0;
      rail_enable_oe_o <= ~next_en;
      fault_o <= 1'b0;
      fault_oe_o <= in_window;
    end
  end

endmodule

// ==== rail_partner.sv ====
// Pull-up loads on the enables and the request line driver
`timescale 1ns/1ps
module rail_partner (
  // From the sequencer and controller
  input wire [3:0] oe_i,
  input wire drive_low_i,
  // Resolved levels
  output wire [3:0] pin_o,
  output wire req_o
);
  // Pull-ups win while no enable pulls low
  assign pin_o = ~oe_i;
  // Request line floats high unless pulled low
  assign req_o = ~drive_low_i;
endmodule

// ==== seq_props.sv ====
// Concurrent checks on the quad rail enable sequencer ports
`timescale 1ns/1ps
module seq_props (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Inputs
  input wire low_limit_sense_i,
  input wire high_limit_sense_i,
  input wire sequence_request_i,
  input wire [15:0] start_delay_capacitor_i,
  input wire [15:0] gap_resistor_ab_i,
  input wire [15:0] gap_resistor_bc_i,
  input wire [15:0] gap_resistor_cd_i,
  // Outputs
  input wire [3:0] rail_enable_o,
  input wire [3:0] rail_enable_oe_o,
  input wire fault_o,
  input wire fault_oe_o
);
  // ****************************************
  // Helper counters
  // ****************************************
  reg [3:0] last;
  reg [31:0] gcnt;
  reg [31:0] scnt;
  wire good = low_limit_sense_i && !high_limit_sense_i;
  // Cycles since enable change, and cycles of window plus request
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last <= 4'hf;
      gcnt <= 32'h0;
      scnt <= 32'h0;
    end else begin
      last <= rail_enable_oe_o;
      gcnt <= (rail_enable_oe_o != last) ? 32'h0 : gcnt + 32'h1;
      scnt <= (good && sequence_request_i) ? scnt + 32'h1 : 32'h0;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire [3:0] oe = rail_enable_oe_o;
  AST_RST_OFF: assert property ($rose(rst_n_i) |-> oe == 4'hf)
    else $error("enables on after reset");
  AST_OD_LOW: assert property (rail_enable_o == 4'h0 && !fault_o)
    else $error("open drain data not low");
  AST_SHAPE: assert property (oe inside {4'hf, 4'he, 4'hc, 4'h8, 4'h0})
    else $error("enable pattern out of order");
  AST_ONE_STEP: assert property ($changed(oe) && oe != 4'hf |->
    oe == {last[2:0], 1'b0} || oe == {1'b1, last[3:1]})
    else $error("enable skipped a step");
  AST_START: assert property ($past(oe) == 4'hf && oe == 4'he |->
    scnt + 3 >= 192 * start_delay_capacitor_i)
    else $error("first enable too early");
  AST_GAP_AB: assert property ($past(oe) == 4'he && oe == 4'hc |->
    gcnt + 3 >= 416 * gap_resistor_ab_i && gcnt <= 416 * gap_resistor_ab_i + 12)
    else $error("gap ab wrong");
  AST_GAP_CD: assert property ($past(oe) == 4'h8 && oe == 4'hc |->
    gcnt + 3 >= 416 * gap_resistor_cd_i && gcnt <= 416 * gap_resistor_cd_i + 12)
    else $error("off gap cd wrong");
  AST_FAULT_FAST: assert property (!good |-> ##[1:5] oe == 4'hf)
    else $error("fault did not drop enables");
  AST_FAULT_GOOD: assert property (good [*8] |-> fault_oe_o)
    else $error("fault reported while compliant");
  AST_FAULT_OFF: assert property (!fault_oe_o |-> oe == 4'hf)
    else $error("enable on during fault");
  // Main scenarios
  COV_ALL_ON: cover property (oe == 4'h0);
  COV_OFF_STEP: cover property ($past(oe) == 4'h8 && oe == 4'hc);
  COV_FAULT_ON: cover property ($past(oe) == 4'h0 && oe == 4'hf);
endmodule

// ==== seq_regs.vh ====
// Timing and step index constants for the quad rail enable sequencer
`ifndef SEQ_REGS_VH
`define SEQ_REGS_VH

// ****************************************
// Clock
// ****************************************
`define CLK_PERIOD_PS 4000

// ****************************************
// Start delay model
// ****************************************
// Start delay per unit of start_delay_capacitor code, in ns (770k ohm * 1 pF)
`define START_NS_PER_UNIT 770
`define START_CYC_PER_UNIT ((`START_NS_PER_UNIT * 1000) / `CLK_PERIOD_PS)
`define START_CODE_W 16
`define START_CNT_W 32

// ****************************************
// Gap oscillator model
// ****************************************
// Gap delay per unit of gap resistor code, in ns (1667 nF * 1 ohm)
`define GAP_NS_PER_UNIT 1667
`define GAP_CYC_PER_UNIT ((`GAP_NS_PER_UNIT * 1000) / `CLK_PERIOD_PS)
`define GAP_CODE_W 16
`define GAP_CNT_W 32

// ****************************************
// Enable step indices
// ****************************************
`define STEP_W 3
`define STEP_NONE 3'h0
`define STEP_ALL 3'h4

`endif

// ==== tb_top.sv ====
// Self-checking testbench for the quad rail enable sequencer
`timescale 1ns/1ps
module tb_top;
  reg clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg low = 1'b0;
  reg high = 1'b0;
  reg req_low = 1'b1;
  reg [15:0] cs = 16'h0001;
  reg [15:0] gab = 16'h0001;
  reg [15:0] gbc = 16'h0000;
  reg [15:0] gcd = 16'h0002;
  wire [3:0] oe;
  wire [3:0] en;
  wire [3:0] pin;
  wire req;
  wire fault;
  wire fault_oe;
  integer mismatches = 0;
  integer checks = 0;
  integer n;
  always #2 clk_i = ~clk_i;
  rail_partner u_partner (.oe_i(oe), .drive_low_i(req_low), .pin_o(pin),
    .req_o(req));
  quad_rail_enable_sequencer u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .low_limit_sense_i(low), .high_limit_sense_i(high),
    .sequence_request_i(req), .start_delay_capacitor_i(cs),
    .gap_resistor_ab_i(gab), .gap_resistor_bc_i(gbc),
    .gap_resistor_cd_i(gcd), .rail_enable_o(en), .rail_enable_oe_o(oe),
    .fault_o(fault), .fault_oe_o(fault_oe));
  // ****************************************
  // Shared tasks
  // ****************************************
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [3:0] got, input [3:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task chk_n(input integer got, input integer lo);
    begin
      checks = checks + 1;
      if (got < lo || got > lo + 12) begin
        mismatches = mismatches + 1;
        $display("Error t=%0t got %h exp %h", $time, got, lo);
      end
    end
  endtask
  task tick(input integer k);
    begin
      repeat (k) @(posedge clk_i);
      #1;
    end
  endtask
  // Bounded wait for an enable pattern; n holds the cycles taken
  task wait_oe(input [3:0] v);
    begin
      n = 0;
      while (oe !== v && n < 4000) begin
        tick(1);
        n = n + 1;
      end
      if (n >= 4000) begin
        $display("Error t=%0t got %h exp %h", $time, oe, v);
        mismatches = mismatches + 1;
        print_verdict;
      end
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task sc_on;
    begin
      low = 1'b1;
      tick(20);
      chk(oe, 4'hf);
      chk({3'h0, fault_oe}, 4'h1);
      req_low = 1'b0;
      wait_oe(4'he);
      chk_n(n, 192 * cs);
      wait_oe(4'hc);
      chk_n(n, 416 * gab);
      wait_oe(4'h8);
      chk_n(n, 416 * gbc);
      wait_oe(4'h0);
      chk_n(n, 416 * gcd);
      chk(pin, 4'hf);
      chk(en, 4'h0);
      chk({3'h0, fault}, 4'h0);
    end
  endtask
  task sc_off;
    begin
      req_low = 1'b1;
      wait_oe(4'h8);
      chk_n(n, 192 * cs);
      wait_oe(4'hc);
      chk_n(n, 416 * gcd);
      wait_oe(4'he);
      chk_n(n, 416 * gbc);
      wait_oe(4'hf);
      chk_n(n, 416 * gab);
    end
  endtask
  // Request dropped during the start delay, then during the on-sequence
  task sc_mid;
    begin
      req_low = 1'b0;
      tick(100);
      req_low = 1'b1;
      tick(200);
      chk(oe, 4'hf);
      req_low = 1'b0;
      wait_oe(4'he);
      chk_n(n, 192 * cs);
      tick(100);
      req_low = 1'b1;
      wait_oe(4'hf);
      chk_n(n, 192 * cs);
    end
  endtask
  task sc_faults;
    begin
      req_low = 1'b0;
      tick(100);
      low = 1'b0;
      tick(400);
      chk(oe, 4'hf);
      chk({3'h0, fault_oe}, 4'h0);
      low = 1'b1;
      wait_oe(4'he);
      chk_n(n, 192 * cs);
      high = 1'b1;
      tick(5);
      chk(oe, 4'hf);
      high = 1'b0;
      wait_oe(4'h0);
      high = 1'b1;
      tick(5);
      chk(oe, 4'hf);
      high = 1'b0;
      wait_oe(4'h0);
      rst_n_i = 1'b0;
      tick(2);
      chk(oe, 4'hf);
      chk({3'h0, fault_oe}, 4'h0);
      rst_n_i = 1'b1;
      tick(10);
      chk(oe, 4'hf);
      chk({3'h0, fault_oe}, 4'h1);
    end
  endtask
  initial begin
    tick(8);
    rst_n_i = 1'b1;
    sc_on;
    sc_off;
    sc_mid;
    sc_faults;
    print_verdict;
  end
endmodule
bind quad_rail_enable_sequencer seq_props u_props (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .low_limit_sense_i(low_limit_sense_i),
  .high_limit_sense_i(high_limit_sense_i),
  .sequence_request_i(sequence_request_i),
  .start_delay_capacitor_i(start_delay_capacitor_i),
  .gap_resistor_ab_i(gap_resistor_ab_i), .gap_resistor_bc_i(gap_resistor_bc_i),
  .gap_resistor_cd_i(gap_resistor_cd_i), .rail_enable_o(rail_enable_o),
  .rail_enable_oe_o(rail_enable_oe_o), .fault_o(fault_o),
  .fault_oe_o(fault_oe_o));
